// *** logic/fcd_pkg.sv ***
`default_nettype none
package fcd_pkg;
    // instruction encodings of the 8-bit core (16-bit words)
    localparam logic [15:0] OP_NOP        = 16'h0000;
    localparam logic [15:0] OP_SET_OVF    = 16'h9438;
    localparam logic [15:0] OP_CLR_OVF    = 16'h94b8;
    localparam logic [15:0] OP_SET_XFER   = 16'h9468;
    localparam logic [15:0] OP_CLR_XFER   = 16'h94e8;
    localparam logic [15:0] OP_SET_HALF   = 16'h9458;
    localparam logic [15:0] OP_CLR_HALF   = 16'h94d8;
    localparam logic [15:0] OP_SLEEP      = 16'h9588;
    localparam logic [15:0] OP_BREAK      = 16'h9598;
    localparam logic [15:0] OP_WDOG       = 16'h95a8;
    // status register bit positions
    localparam int unsigned BIT_HALF = 5;
    localparam int unsigned BIT_XFER = 6;
    localparam int unsigned BIT_OVF  = 3;
    localparam logic [7:0]  STATUS_RESET = 8'h00;
    localparam int unsigned GUARD_NOPS = 8;

    typedef enum logic [3:0] {
        FCD_K_OTHER = 4'b0000,
        FCD_K_NOP   = 4'b0001,
        FCD_K_SETV  = 4'b0010,
        FCD_K_CLRV  = 4'b0011,
        FCD_K_SETT  = 4'b0100,
        FCD_K_CLRT  = 4'b0101,
        FCD_K_SETH  = 4'b0110,
        FCD_K_CLRH  = 4'b0111,
        FCD_K_SLEEP = 4'b1000,
        FCD_K_WDOG  = 4'b1001,
        FCD_K_BREAK = 4'b1010
    } fcd_kind_t;

    typedef struct packed {
        logic sleep_req;
        logic wdog_restart;
        logic break_req;
    } fcd_ctrl_t;
endpackage
`default_nettype wire

// *** logic/fcd_classify.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcd_classify
    import fcd_pkg::*;
(
    // instruction word
    input  wire logic [15:0] insn,
    // decoded kind
    output fcd_kind_t        kind
);
    always_comb begin
        unique case (insn)
            OP_NOP:      kind = FCD_K_NOP;
            OP_SET_OVF:  kind = FCD_K_SETV;
            OP_CLR_OVF:  kind = FCD_K_CLRV;
            OP_SET_XFER: kind = FCD_K_SETT;
            OP_CLR_XFER: kind = FCD_K_CLRT;
            OP_SET_HALF: kind = FCD_K_SETH;
            OP_CLR_HALF: kind = FCD_K_CLRH;
            OP_SLEEP:    kind = FCD_K_SLEEP;
            OP_WDOG:     kind = FCD_K_WDOG;
            OP_BREAK:    kind = FCD_K_BREAK;
            default:     kind = FCD_K_OTHER;
        endcase
    end
endmodule // fcd_classify
`default_nettype wire

// *** logic/fcd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcd_decoder
    import fcd_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // instruction issue
    input  wire logic       insn_valid,
    input  wire logic [15:0] insn,
    input  wire logic       debug_enable,
    // status register from core datapath
    input  wire logic       status_wr,
    input  wire logic [7:0] status_wdata,
    // results
    output logic [7:0]      status_register,
    output fcd_ctrl_t       ctrl,
    output logic            insn_done,
    output logic            insn_handled
);
    fcd_kind_t kind;
    logic      is_ours;

    fcd_classify u_classify (
        .insn (insn),
        .kind (kind)
    );

    assign is_ours = insn_valid && (kind != FCD_K_OTHER);

    // flag updates: each touches only its own bit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_register <= STATUS_RESET;
        end else if (clk_en) begin
            if (insn_valid) begin
                unique case (kind)
                    FCD_K_SETV: status_register[BIT_OVF]  <= 1'b1;
                    FCD_K_CLRV: status_register[BIT_OVF]  <= 1'b0;
                    FCD_K_SETH: status_register[BIT_HALF] <= 1'b1;
                    FCD_K_CLRH: status_register[BIT_HALF] <= 1'b0;
                    FCD_K_SETT: status_register[BIT_XFER] <= 1'b1;
                    FCD_K_CLRT: status_register[BIT_XFER] <= 1'b0;
                    FCD_K_OTHER: begin
                        if (status_wr) begin
                            status_register <= status_wdata;
                        end
                    end
                    default: ; // nop, sleep, watchdog, break keep flags
                endcase
            end else if (status_wr) begin
                status_register <= status_wdata;
            end
        end
    end

    // control pulses, one cycle each
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= '0;
        end else if (clk_en) begin
            ctrl.sleep_req    <= insn_valid && kind == FCD_K_SLEEP;
            ctrl.wdog_restart <= insn_valid && kind == FCD_K_WDOG;
            ctrl.break_req    <= insn_valid && kind == FCD_K_BREAK && debug_enable;
        end
    end

    // completion: every handled op except break with debug_enable low finishes in one cycle; nop is pure (no state)
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            insn_done    <= 1'b0;
            insn_handled <= 1'b0;
        end else if (clk_en) begin
            insn_done    <= is_ours && (kind != FCD_K_BREAK || debug_enable);
            insn_handled <= is_ours;
        end
    end

    property p_setv;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_SETV |=> status_register[BIT_OVF]
            && status_register[7:4] == $past(status_register[7:4])
            && status_register[2:0] == $past(status_register[2:0]);
    endproperty
    a_setv: assert property (p_setv) else $error("set overflow wrong");

    property p_clrv;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_CLRV |=> !status_register[BIT_OVF]
            && status_register[7:4] == $past(status_register[7:4])
            && status_register[2:0] == $past(status_register[2:0]);
    endproperty
    a_clrv: assert property (p_clrv) else $error("clear overflow wrong");

    property p_seth;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_SETH |=> status_register[BIT_HALF]
            && status_register[4:0] == $past(status_register[4:0]);
    endproperty
    a_seth: assert property (p_seth) else $error("set half carry wrong");

    property p_clrh;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_CLRH |=> !status_register[BIT_HALF]
            && status_register[7:6] == $past(status_register[7:6])
            && status_register[4:0] == $past(status_register[4:0]);
    endproperty
    a_clrh: assert property (p_clrh) else $error("clear half carry wrong");

    property p_sleep;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_SLEEP && !status_wr |=>
            ctrl.sleep_req && insn_done && $stable(status_register);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep wrong");

    property p_wdog;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_WDOG ##1 clk_en && !(insn_valid && kind == FCD_K_WDOG)
            |-> ctrl.wdog_restart ##1 !ctrl.wdog_restart;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog pulse wrong");

    property p_break;
        @(posedge sys_clk) disable iff (!rst_b)
        $past(clk_en) && ctrl.break_req |-> $past(debug_enable) && $past(insn_valid)
            && $past(kind) == FCD_K_BREAK;
    endproperty
    a_break: assert property (p_break) else $error("break without debug");

    property p_nop;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_NOP && !status_wr |=>
            insn_done && ctrl == '0 && $stable(status_register);
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");

    property p_sett;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_SETT |=> status_register[BIT_XFER]
            && status_register[5:0] == $past(status_register[5:0]);
    endproperty
    a_sett: assert property (p_sett) else $error("set transfer wrong");

    property p_clrt;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_CLRT |=> !status_register[BIT_XFER]
            && status_register[7] == $past(status_register[7])
            && status_register[5:0] == $past(status_register[5:0]);
    endproperty
    a_clrt: assert property (p_clrt) else $error("clear transfer wrong");

    property p_flag_done;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind inside {FCD_K_SETV, FCD_K_CLRV, FCD_K_SETT,
            FCD_K_CLRT, FCD_K_SETH, FCD_K_CLRH} |=> insn_done && insn_handled && ctrl == '0;
    endproperty
    a_flag_done: assert property (p_flag_done) else $error("flag op not done");

    property p_sleep_pulse;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_SLEEP ##1 clk_en && !(insn_valid && kind == FCD_K_SLEEP)
            |-> ctrl.sleep_req ##1 !ctrl.sleep_req;
    endproperty
    a_sleep_pulse: assert property (p_sleep_pulse) else $error("sleep pulse wrong");

    property p_wdog_flags;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_WDOG |=>
            insn_done && $stable(status_register);
    endproperty
    a_wdog_flags: assert property (p_wdog_flags) else $error("watchdog changed flags");

    property p_break_flags;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_BREAK |=>
            insn_handled && $stable(status_register);
    endproperty
    a_break_flags: assert property (p_break_flags) else $error("break changed flags");

    property p_break_off;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_BREAK && !debug_enable |=>
            !ctrl.break_req && !insn_done;
    endproperty
    a_break_off: assert property (p_break_off) else $error("break acted without debug");

    property p_handled;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && !is_ours |=> !insn_handled && !insn_done;
    endproperty
    a_handled: assert property (p_handled) else $error("foreign insn handled");

    // datapath write lands when no op of ours competes
    property p_status_wr;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en && status_wr && !is_ours |=> status_register == $past(status_wdata);
    endproperty
    a_status_wr: assert property (p_status_wr) else $error("datapath write lost");

    // a low clock enable freezes every output
    property p_frozen;
        @(posedge sys_clk) disable iff (!rst_b)
        !clk_en |=> $stable(status_register) && $stable(ctrl)
            && $stable(insn_done) && $stable(insn_handled);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while frozen");

    c_eight_nops: cover property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && insn_valid && kind == FCD_K_NOP) [*8]);
    c_wdog: cover property (@(posedge sys_clk) disable iff (!rst_b) ctrl.wdog_restart);
    c_break: cover property (@(posedge sys_clk) disable iff (!rst_b) ctrl.break_req);
    c_sleep: cover property (@(posedge sys_clk) disable iff (!rst_b) ctrl.sleep_req);
    c_refused_break: cover property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && insn_valid && kind == FCD_K_BREAK && !debug_enable);
endmodule // fcd_decoder
`default_nettype wire

// *** sim/flag_and_control_op_decoder_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module flag_and_control_op_decoder_bench
    import fcd_pkg::*;
;
    logic        sys_clk, rst_b, clk_en, insn_valid, debug_enable, status_wr;
    logic [15:0] insn;
    logic [7:0]  status_wdata, status_register, exp_st;
    fcd_ctrl_t   ctrl;
    logic        insn_done, insn_handled;
    int          n_mismatch, checks;
    localparam logic [15:0] OPS [10] = '{OP_NOP, OP_SET_OVF, OP_CLR_OVF, OP_SET_XFER,
        OP_CLR_XFER, OP_SET_HALF, OP_CLR_HALF, OP_SLEEP, OP_BREAK, OP_WDOG};

    fcd_decoder i_fcd_decoder (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .insn_valid(insn_valid), .insn(insn), .debug_enable(debug_enable),
        .status_wr(status_wr), .status_wdata(status_wdata),
        .status_register(status_register), .ctrl(ctrl), .insn_done(insn_done),
        .insn_handled(insn_handled));

    always #5 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // model the edge just reached from the inputs it sampled, then drive the next cycle
    task automatic step(input logic en, input logic v, input logic [15:0] op,
                        input logic dbg, input logic wr, input logic [7:0] wd);
        logic       ours, en0, refused;
        logic [2:0] ep;
        @(posedge sys_clk);
        en0     = clk_en;
        ours    = insn_valid && (insn inside {OPS});
        refused = insn_valid && insn == OP_BREAK && !debug_enable;
        ep = {insn_valid && insn == OP_SLEEP, insn_valid && insn == OP_WDOG,
              insn_valid && insn == OP_BREAK && debug_enable};
        if (en0 && ours) begin
            case (insn)
                OP_SET_OVF:  exp_st[BIT_OVF]  = 1'b1;
                OP_CLR_OVF:  exp_st[BIT_OVF]  = 1'b0;
                OP_SET_XFER: exp_st[BIT_XFER] = 1'b1;
                OP_CLR_XFER: exp_st[BIT_XFER] = 1'b0;
                OP_SET_HALF: exp_st[BIT_HALF] = 1'b1;
                OP_CLR_HALF: exp_st[BIT_HALF] = 1'b0;
                default: ;
            endcase
        end else if (en0 && status_wr) begin
            exp_st = status_wdata;
        end
        clk_en       <= en;
        insn_valid   <= v;
        insn         <= op;
        debug_enable <= dbg;
        status_wr    <= wr;
        status_wdata <= wd;
        #1;
        check("status", exp_st, status_register);
        if (en0) begin
            check("ctrl", {5'h00, ep}, {5'h00, ctrl});
            check("done", {7'h00, ours && !refused}, {7'h00, insn_done});
            check("handled", {7'h00, ours}, {7'h00, insn_handled});
        end
    endtask

    initial begin
        logic [31:0] r;
        logic [15:0] op;
        sys_clk = 0; rst_b = 0; clk_en = 0; insn_valid = 0; insn = 16'h0000;
        debug_enable = 0; status_wr = 0; status_wdata = 8'h00;
        exp_st = STATUS_RESET; n_mismatch = 0; checks = 0;
        void'($urandom(22904));
        repeat (8) @(posedge sys_clk);
        check("reset status", STATUS_RESET, status_register);
        rst_b <= 1'b1;
        // every op on all-zero and all-one flags, debug off and on
        for (int i = 0; i < 10; i++)
            for (int d = 0; d < 4; d++) begin
                step(1, 0, 16'h0000, d[0], 1, d[1] ? 8'hff : 8'h00);
                step(1, 1, OPS[i], d[0], 0, 8'h00);
            end
        // guard run of no-ops, each racing a datapath write
        for (int i = 0; i < GUARD_NOPS; i++) step(1, 1, OP_NOP, 0, 1, 8'ha5);
        step(0, 1, OP_SET_OVF, 1, 0, 8'h00); // frozen cycle holds state
        step(1, 1, OP_WDOG, 0, 0, 8'h00);
        repeat (3000) begin
            r  = $urandom;
            op = (r[3:0] < 10) ? OPS[r[3:0]] : r[31:16];
            step(r[7:5] != 0, r[8] | r[9], op, r[10],
                 (op == OP_BREAK) ? 1'b0 : r[4], 8'($urandom));
        end
        step(1, 0, 16'h0000, 0, 0, 8'h00);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("mid-run reset status", STATUS_RESET, status_register);
        rst_b <= 1'b1;
        exp_st = STATUS_RESET;
        for (int i = 0; i < 10; i++) step(1, 1, OPS[i], 1, 0, 8'h00);
        step(1, 0, 16'h0000, 0, 0, 8'h00);
        summarize();
    end
endmodule // flag_and_control_op_decoder_bench
`default_nettype wire
